// [logic/scx_defines.svh]
// Offsets, field positions, reset values and timing counts for strap logic
`ifndef SCX_DEFINES_SVH
`define SCX_DEFINES_SVH

// ****************************************************************
// Register offsets on the management register port
// ****************************************************************
`define SCX_ADDR_W             5
`define SCX_DATA_W             16
`define SCX_OFS_STRAP_ONE      5'h09
`define SCX_OFS_STRAP_THREE    5'h0B
`define SCX_OFS_ACCESS_CTRL    5'h0D
`define SCX_OFS_ADDR_DATA      5'h0E

// ****************************************************************
// Field positions
// ****************************************************************
`define SCX_CFG_DONE_BIT       15
`define SCX_POL_SWAP_BIT       6
`define SCX_PAIR_SWAP_BIT      5
`define SCX_BYPASS_BIT         4
`define SCX_FLD_SPARE_RX_BIT_OUTPUT_BIT      3
`define SCX_FLD_MLT3_BIT       2
`define SCX_FLD_SNR_BIT        1
`define SCX_FLD_ENERGY_BIT     0
`define SCX_STRAP_THREE_MSB    6
`define SCX_FN_MSB             15
`define SCX_FN_LSB             14
`define SCX_TARGET_DEVICE_ADDRESS_MSB          4
`define SCX_VENDOR_TARGET_DEVICE_ADDRESS       5'h1F

// ****************************************************************
// Reset values
// ****************************************************************
`define SCX_STRAP_THREE_RST    7'h00
`define SCX_TARGET_DEVICE_ADDRESS_RST          5'h00
`define SCX_POINTER_RST        16'h0000

// ****************************************************************
// Extended register window
// ****************************************************************
`define SCX_EXT_BASE           16'h0020
`define SCX_EXT_DEPTH          32
`define SCX_EXT_IDX_W          5

// ****************************************************************
// Fast link-down timing and thresholds
// ****************************************************************
`define SCX_CLK_PERIOD_NS      50
`define SCX_WINDOW_NS          10000
`define SCX_WINDOW_CYCLES      (`SCX_WINDOW_NS / `SCX_CLK_PERIOD_NS)
`define SCX_WIN_CNT_W          8
`define SCX_EVT_CNT_W          6
`define SCX_SPARE_RX_BIT_OUTPUT_LIMIT        6'h20
`define SCX_MLT3_LIMIT         6'h14
`define SCX_SNR_LIMIT          6'h14

`endif

// [logic/scx_event_window.sv]
// Counts events inside one measuring interval and flags a threshold hit
`timescale 1ns/10ps
`include "scx_defines.svh"

module scx_event_window #(
  parameter logic [`SCX_EVT_CNT_W-1:0] LIMIT = `SCX_SPARE_RX_BIT_OUTPUT_LIMIT
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  wire logic tick_in,
  input  wire logic event_in,
  output logic      hit_out
);

  logic [`SCX_EVT_CNT_W-1:0] count;
  logic [`SCX_EVT_CNT_W-1:0] next_count;
  wire                       reach;

  // Limit reached by the event arriving this cycle; an event on the
  // tick belongs to the new interval and never completes the old one
  assign reach = enable_in && event_in && !tick_in
                 && (count == LIMIT - `SCX_EVT_CNT_W'(1));

  // ****************************************************************
  // Event counter, restarted by each interval tick
  // ****************************************************************
  always_comb
  begin
    if (!enable_in || reach)
      next_count = '0;
    else if (tick_in)
      next_count = event_in ? `SCX_EVT_CNT_W'(1) : '0;
    else if (event_in)
      next_count = count + `SCX_EVT_CNT_W'(1);
    else
      next_count = count;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count   <= '0;
      hit_out <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      hit_out <= reach;
    end
  end

endmodule

// [logic/scx_ext_regfile.sv]
// Storage for the extended register set behind the indirect access path
`timescale 1ns/10ps
`include "scx_defines.svh"

module scx_ext_regfile (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [`SCX_DATA_W-1:0]   pointer_in,
  input  wire logic                     write_in,
  input  wire logic [`SCX_DATA_W-1:0]   wdata_in,
  output logic      [`SCX_DATA_W-1:0]   rdata_out
);

  logic [`SCX_DATA_W-1:0] mem [`SCX_EXT_DEPTH];
  wire                    in_window;
  wire [`SCX_DATA_W-1:0]  offset;
  wire [`SCX_EXT_IDX_W-1:0] index;

  // Only pointers inside the implemented window reach storage
  assign offset    = pointer_in - `SCX_EXT_BASE;
  assign in_window = (pointer_in >= `SCX_EXT_BASE)
                     && (offset < `SCX_DATA_W'(`SCX_EXT_DEPTH));
  assign index     = offset[`SCX_EXT_IDX_W-1:0];
  assign rdata_out = in_window ? mem[index] : '0;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `SCX_EXT_DEPTH; i++)
        mem[i] <= '0;
    end
    else if (write_in && in_window)
      mem[index] <= wdata_in;
  end

endmodule

// [logic/scx_pkg.sv]
// Types shared by the strap and indirect access logic
package scx_pkg;

  // ****************************************************************
  // Function field of the access-control register
  // ****************************************************************
  typedef enum logic [1:0] {
    SCX_FN_ADDRESS,
    SCX_FN_DATA_HOLD,
    SCX_FN_DATA_INC_RW,
    SCX_FN_DATA_INC_WR
  } scx_fn_t;

endpackage

// [logic/scx_strap_regs.sv]
// Software strap register three, strap latch, fast link-down, indirect path
`timescale 1ns/10ps
`include "scx_defines.svh"

module scx_strap_regs (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [`SCX_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`SCX_DATA_W-1:0]  reg_wdata_in,
  input  wire logic                    reg_write_in,
  input  wire logic                    reg_read_in,
  input  wire logic                    spare_tx_pin_in,
  input  wire logic                    rx_symbol_bit4_in,
  input  wire logic                    rx_error_in,
  input  wire logic                    rx_error_event_in,
  input  wire logic                    mlt3_violation_in,
  input  wire logic                    low_snr_in,
  input  wire logic                    energy_loss_in,
  output logic      [`SCX_DATA_W-1:0]  reg_rdata_out,
  output logic                         reg_rdata_valid_out,
  output logic                         config_done_out,
  output logic                         internal_reset_out,
  output logic                         polarity_swap_out,
  output logic                         pair_swap_out,
  output logic                         port_mirror_out,
  output logic                         bypass_4b5b_out,
  output logic                         tx_symbol_bit4_out,
  output logic                         spare_rx_bit_output_out,
  output logic                         link_drop_out
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Any function code but address sends data accesses to storage
  function automatic logic is_data_fn(input scx_pkg::scx_fn_t fn);
    is_data_fn = (fn != scx_pkg::SCX_FN_ADDRESS);
  endfunction

  function automatic logic post_inc(input scx_pkg::scx_fn_t fn,
                                    input logic            is_write);
    case (fn)
      scx_pkg::SCX_FN_DATA_INC_RW: post_inc = 1'b1;
      scx_pkg::SCX_FN_DATA_INC_WR: post_inc = is_write;
      default:                     post_inc = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [`SCX_STRAP_THREE_MSB:0] strap_config_three;
  scx_pkg::scx_fn_t              access_fn;
  logic [`SCX_TARGET_DEVICE_ADDRESS_MSB:0]       target_device_address;
  logic [`SCX_DATA_W-1:0]        ext_pointer;
  logic [`SCX_WIN_CNT_W-1:0]     window_count;
  logic                          window_tick;
  logic                          spare_tx_meta;
  logic                          spare_tx_sync;
  logic [`SCX_DATA_W-1:0]        ext_rdata;
  logic                          hit_spare_rx_bit_output;
  logic                          hit_mlt3;
  logic                          hit_snr;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // One select per implemented offset; all others read zero
  wire sel_one    = (reg_addr_in == `SCX_OFS_STRAP_ONE);
  wire sel_three  = (reg_addr_in == `SCX_OFS_STRAP_THREE);
  wire sel_ctrl   = (reg_addr_in == `SCX_OFS_ACCESS_CTRL);
  wire sel_data   = (reg_addr_in == `SCX_OFS_ADDR_DATA);

  wire wr_one     = reg_write_in && sel_one;
  wire wr_three   = reg_write_in && sel_three;
  wire wr_ctrl    = reg_write_in && sel_ctrl;

  // Indirect data path only answers the vendor device address
  wire target_device_address_ok   = (target_device_address == `SCX_VENDOR_TARGET_DEVICE_ADDRESS);
  wire data_wr    = reg_write_in && sel_data && target_device_address_ok;
  wire data_rd    = reg_read_in && sel_data && target_device_address_ok;
  wire data_mode  = is_data_fn(access_fn);

  // Config done seen on a strap register one write
  wire cfg_done_wr = wr_one && reg_wdata_in[`SCX_CFG_DONE_BIT];

  // Pointer load or post-increment
  wire ptr_load   = data_wr && !data_mode;
  wire ptr_inc    = (data_wr || data_rd) && data_mode
                    && post_inc(access_fn, data_wr);
  wire ext_write  = data_wr && data_mode;

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  wire [`SCX_DATA_W-1:0] rd_one =
    {config_done_out, {(`SCX_DATA_W-1){1'b0}}};
  wire [`SCX_DATA_W-1:0] rd_three =
    {{(`SCX_DATA_W-`SCX_STRAP_THREE_MSB-1){1'b0}},
     strap_config_three};
  wire [`SCX_DATA_W-1:0] rd_ctrl =
    {access_fn,
     {(`SCX_FN_LSB-`SCX_TARGET_DEVICE_ADDRESS_MSB-1){1'b0}},
     target_device_address};
  // Address mode reads back the pointer, data modes read storage
  wire [`SCX_DATA_W-1:0] rd_data =
    !target_device_address_ok ? '0 :
    data_mode ? ext_rdata : ext_pointer;
  wire [`SCX_DATA_W-1:0] next_rdata =
    sel_one   ? rd_one   :
    sel_three ? rd_three :
    sel_ctrl  ? rd_ctrl  :
    sel_data  ? rd_data  : '0;

  // ****************************************************************
  // Extended register storage
  // ****************************************************************
  scx_ext_regfile u_ext_regfile (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .pointer_in (ext_pointer),
    .write_in   (ext_write),
    .wdata_in   (reg_wdata_in),
    .rdata_out  (ext_rdata)
  );

  // ****************************************************************
  // Management register writes and read answer
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_config_three    <= `SCX_STRAP_THREE_RST;
      access_fn             <= scx_pkg::SCX_FN_ADDRESS;
      target_device_address <= `SCX_TARGET_DEVICE_ADDRESS_RST;
      ext_pointer           <= `SCX_POINTER_RST;
      reg_rdata_out         <= '0;
      reg_rdata_valid_out   <= 1'b0;
    end
    else
    begin
      if (wr_three)
        strap_config_three <= reg_wdata_in[`SCX_STRAP_THREE_MSB:0];
      if (wr_ctrl)
      begin
        access_fn <= scx_pkg::scx_fn_t'(
                       reg_wdata_in[`SCX_FN_MSB:`SCX_FN_LSB]);
        target_device_address <= reg_wdata_in[`SCX_TARGET_DEVICE_ADDRESS_MSB:0];
      end
      if (ptr_load)
        ext_pointer <= reg_wdata_in;
      else if (ptr_inc)
        ext_pointer <= ext_pointer + `SCX_DATA_W'(1);
      // Read data is captured only on a read and stands until the next
      reg_rdata_valid_out <= reg_read_in;
      if (reg_read_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************************************
  // Strap latch on configuration complete
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      config_done_out    <= 1'b0;
      internal_reset_out <= 1'b0;
      polarity_swap_out  <= 1'b0;
      pair_swap_out      <= 1'b0;
      port_mirror_out    <= 1'b0;
      bypass_4b5b_out    <= 1'b0;
    end
    else
    begin
      internal_reset_out <= cfg_done_wr;
      // Takes the straps stored before this write; a same-cycle strap
      // write is picked up only by the next config-done write
      if (cfg_done_wr)
      begin
        config_done_out   <= 1'b1;
        polarity_swap_out <= strap_config_three[`SCX_POL_SWAP_BIT];
        pair_swap_out     <= strap_config_three[`SCX_PAIR_SWAP_BIT];
        port_mirror_out   <= strap_config_three[`SCX_POL_SWAP_BIT]
                             && strap_config_three[`SCX_PAIR_SWAP_BIT];
        bypass_4b5b_out   <= strap_config_three[`SCX_BYPASS_BIT];
      end
    end
  end

  // ****************************************************************
  // Fifth symbol bit on the spare pins
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      spare_tx_meta           <= 1'b0;
      spare_tx_sync           <= 1'b0;
      tx_symbol_bit4_out      <= 1'b0;
      spare_rx_bit_output_out <= 1'b0;
    end
    else
    begin
      // Pin is asynchronous: only the second flop feeds logic
      spare_tx_meta           <= spare_tx_pin_in;
      spare_tx_sync           <= spare_tx_meta;
      tx_symbol_bit4_out      <= bypass_4b5b_out && spare_tx_sync;
      spare_rx_bit_output_out <= bypass_4b5b_out ? rx_symbol_bit4_in
                                                 : rx_error_in;
    end
  end

  // ****************************************************************
  // Fast link-down measuring interval
  // ****************************************************************
  // Tick marks the first cycle of each fixed measuring interval
  wire window_last =
    (window_count == `SCX_WIN_CNT_W'(`SCX_WINDOW_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      window_count <= '0;
      window_tick  <= 1'b0;
    end
    else
    begin
      window_count <= window_last ? '0 : window_count + `SCX_WIN_CNT_W'(1);
      window_tick  <= window_last;
    end
  end

  scx_event_window #(.LIMIT(`SCX_SPARE_RX_BIT_OUTPUT_LIMIT)) u_win_spare_rx_bit_output (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .enable_in (strap_config_three[`SCX_FLD_SPARE_RX_BIT_OUTPUT_BIT]),
    .tick_in   (window_tick),
    .event_in  (rx_error_event_in),
    .hit_out   (hit_spare_rx_bit_output)
  );

  scx_event_window #(.LIMIT(`SCX_MLT3_LIMIT)) u_win_mlt3 (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .enable_in (strap_config_three[`SCX_FLD_MLT3_BIT]),
    .tick_in   (window_tick),
    .event_in  (mlt3_violation_in),
    .hit_out   (hit_mlt3)
  );

  scx_event_window #(.LIMIT(`SCX_SNR_LIMIT)) u_win_snr (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .enable_in (strap_config_three[`SCX_FLD_SNR_BIT]),
    .tick_in   (window_tick),
    .event_in  (low_snr_in),
    .hit_out   (hit_snr)
  );

  // ****************************************************************
  // Link drop decision
  // ****************************************************************
  // Energy loss acts at once; it does not wait for an interval
  wire energy_drop    = strap_config_three[`SCX_FLD_ENERGY_BIT]
                        && energy_loss_in;
  wire count_drop     = hit_spare_rx_bit_output || hit_mlt3 || hit_snr;
  // Any enabled criterion drops the link
  wire next_link_drop = count_drop || energy_drop;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      link_drop_out <= 1'b0;
    else
      link_drop_out <= next_link_drop;
  end

endmodule

// [tb/scx_host_model.sv]
// Management host model driving the register strobe port
`timescale 1ns/10ps

module scx_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [4:0]  addr_out = 5'h00,
  output logic      [15:0] wdata_out = 16'h0000,
  output logic             write_out = 1'b0,
  output logic             read_out = 1'b0
);
  // Released lines carry inverted values so stale data is never trusted
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    write_out = 1'b1;
    @(negedge clk_in);
    write_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge clk_in);
    addr_out = a;
    read_out = 1'b1;
    @(negedge clk_in);
    read_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
    v = rvalid_in;
  endtask
endmodule

// [tb/scx_strap_regs_assertions.sv]
// Assertions on the strap and indirect register port
`timescale 1ns/10ps

module scx_strap_regs_assertions (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rdata_valid_out,
  input wire logic        config_done_out,
  input wire logic        internal_reset_out,
  input wire logic        polarity_swap_out,
  input wire logic        pair_swap_out,
  input wire logic        port_mirror_out,
  input wire logic        bypass_4b5b_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_rd(logic [4:0] ofs);
    reg_read_in && reg_addr_in == ofs;
  endsequence
  sequence s_done_wr;
    reg_write_in && reg_addr_in == 5'h09 && reg_wdata_in[15];
  endsequence

  chk_done_pulse: assert property (s_done_wr |=>
    internal_reset_out && config_done_out)
    else $error("no reset pulse after config done write");
  chk_strap_hold: assert property (($changed(polarity_swap_out) ||
    $changed(pair_swap_out) || $changed(bypass_4b5b_out)) |->
    internal_reset_out)
    else $error("strap output moved without reset pulse");
  chk_mirror_both: assert property (
    port_mirror_out == (polarity_swap_out && pair_swap_out))
    else $error("mirror does not follow both swap bits");
  chk_strap3_zero: assert property (s_rd(5'h0B) |=>
    reg_rdata_valid_out && reg_rdata_out[15:7] == 9'h000)
    else $error("reserved strap bits read nonzero");
  chk_ctrl_zero: assert property (s_rd(5'h0D) |=>
    reg_rdata_out[13:5] == 9'h000)
    else $error("reserved control bits read nonzero");
  chk_unmapped_zero: assert property (s_rd(5'h1A) |=>
    reg_rdata_out == 16'h0000)
    else $error("unmapped offset read nonzero");
  chk_done_read: assert property (s_rd(5'h09) |=>
    reg_rdata_out[14:0] == 15'h0000)
    else $error("config done register has stray bits");
  chk_valid_timing: assert property ($past(rst_n_in) |->
    reg_rdata_valid_out == $past(reg_read_in))
    else $error("read valid not one cycle after read");
endmodule

bind scx_strap_regs scx_strap_regs_assertions u_chk (
  .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
  .reg_read_in, .reg_rdata_out, .reg_rdata_valid_out, .config_done_out,
  .internal_reset_out, .polarity_swap_out, .pair_swap_out,
  .port_mirror_out, .bypass_4b5b_out
);

// [tb/scx_strap_regs_tb_top.sv]
// Self-checking bench for the strap and indirect access logic
`timescale 1ns/10ps

module scx_strap_regs_tb_top;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic        wr, rd, rvalid, done, ireset, pol, pair, mirror;
  logic        bypass, tx_sym, spare_rx, drop;
  logic        tx_pin = 1'b0, rx_sym = 1'b0, rx_err = 1'b0;
  logic        energy = 1'b0;
  logic [2:0]  evt = 3'h0;
  int          err_total = 0;
  int          n_checks = 0;

  always #25 clk_in = ~clk_in;

  scx_host_model host (.clk_in(clk_in), .rdata_in(rdata),
    .rvalid_in(rvalid), .addr_out(addr), .wdata_out(wdata),
    .write_out(wr), .read_out(rd));

  scx_strap_regs uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .spare_tx_pin_in(tx_pin),
    .rx_symbol_bit4_in(rx_sym), .rx_error_in(rx_err),
    .rx_error_event_in(evt[0]), .mlt3_violation_in(evt[1]),
    .low_snr_in(evt[2]), .energy_loss_in(energy),
    .reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid),
    .config_done_out(done), .internal_reset_out(ireset),
    .polarity_swap_out(pol), .pair_swap_out(pair),
    .port_mirror_out(mirror), .bypass_4b5b_out(bypass),
    .tx_symbol_bit4_out(tx_sym), .spare_rx_bit_output_out(spare_rx),
    .link_drop_out(drop));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.rd(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic ptr_is(input logic [15:0] p);
    host.wr(5'h0D, 16'h001F);
    rdchk(5'h0E, p);
  endtask

  task automatic t_reset;
    chk(done, 1'b0);
    rdchk(5'h0D, 16'h0000);
    ptr_is(16'h0000);
    $display("reset values test done");
  endtask

  task automatic t_straps;
    logic [15:0] tab [4] = '{16'h0070, 16'h0040, 16'h0020, 16'h0000};
    host.wr(5'h0B, 16'hFFFF);
    rdchk(5'h0B, 16'h007F);
    rx_sym = 1'b1;
    tx_pin = 1'b1; // MAC side runs MII whenever bypass is set
    foreach (tab[i])
    begin
      host.wr(5'h0B, tab[i]);
      host.wr(5'h09, 16'h8000);
      chk(ireset, 1'b1);
      chk(done, 1'b1);
      repeat (4) @(negedge clk_in);
      chk(ireset, 1'b0);
      chk(pol, tab[i][6]);
      chk(pair, tab[i][5]);
      chk(mirror, tab[i][6] & tab[i][5]);
      chk(bypass, tab[i][4]);
      chk(spare_rx, tab[i][4]);
      chk(tx_sym, tab[i][4]);
    end
    rx_err = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(spare_rx, 1'b1);
    rx_err = 1'b0;
    $display("strap test done");
  endtask

  task automatic run_evt(input int i, input logic [15:0] en,
                         input int gap, output logic seen);
    seen = 1'b0;
    host.wr(5'h0B, 16'h0000);
    host.wr(5'h0B, en);
    for (int c = 0; c < 450; c++)
    begin
      @(negedge clk_in);
      evt[i] = (c < 440) && (c % gap == 0);
      seen |= drop;
    end
  endtask

  task automatic t_fast_down;
    logic s;
    for (int i = 0; i < 3; i++)
    begin
      run_evt(i, 16'h0008 >> i, (i == 0) ? 6 : 10, s);
      chk(s, 1'b1);
      run_evt(i, 16'h0008 >> i, (i == 0) ? 7 : 11, s);
      chk(s, 1'b0);
      run_evt(i, 16'h000E ^ (16'h0008 >> i), 1, s);
      chk(s, 1'b0);
    end
    host.wr(5'h0B, 16'h0001);
    energy = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(drop, 1'b1);
    host.wr(5'h0B, 16'h000E);
    repeat (2) @(negedge clk_in);
    chk(drop, 1'b0);
    energy = 1'b0;
    $display("fast link down test done");
  endtask

  task automatic t_indirect;
    host.wr(5'h0E, 16'h0020);
    rdchk(5'h0E, 16'h0020);
    host.wr(5'h0D, 16'h401F);
    host.wr(5'h0E, 16'hA5A5);
    rdchk(5'h0E, 16'hA5A5);
    rdchk(5'h0E, 16'hA5A5);
    host.wr(5'h0D, 16'h801F);
    host.wr(5'h0E, 16'h1111);
    host.wr(5'h0E, 16'h2222);
    ptr_is(16'h0022);
    host.wr(5'h0E, 16'h0020);
    host.wr(5'h0D, 16'h801F);
    rdchk(5'h0E, 16'h1111);
    rdchk(5'h0E, 16'h2222);
    host.wr(5'h0D, 16'hC01F);
    host.wr(5'h0E, 16'h3333);
    ptr_is(16'h0023);
    host.wr(5'h0E, 16'h0022);
    host.wr(5'h0D, 16'hC01F);
    rdchk(5'h0E, 16'h3333);
    rdchk(5'h0E, 16'h3333);
    host.wr(5'h0D, 16'h4001);
    host.wr(5'h0E, 16'hBEEF);
    rdchk(5'h0E, 16'h0000);
    host.wr(5'h0D, 16'h401F);
    rdchk(5'h0E, 16'h3333);
    host.wr(5'h0D, 16'hFFFF);
    rdchk(5'h0D, 16'hC01F);
    rdchk(5'h1A, 16'h0000);
    $display("indirect access test done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset;
    t_straps;
    t_fast_down;
    t_indirect;
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset;
    summarize;
  end

  initial
  begin
    #(20000 * 50);
    err_total++;
    summarize;
  end
endmodule
